//--- ifeb_bank.sv
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module ifeb_bank #(
  parameter int NGRP = 4
) (
  input  wire logic        clk,             // system clock
  input  wire logic        sys_rst,         // async reset, high
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb enable
  input  wire logic        pwrite,          // apb direction
  input  wire logic [11:0] paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  input  wire logic [3:0]  pstrb,           // apb byte strobes
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error
  input  wire logic [15:0] src_group2,      // group2 source pulses
  input  wire logic [15:0] src_group3,      // group3 source pulses
  input  wire logic [15:0] src_group4,      // group4 source pulses
  input  wire logic [15:0] src_group0,      // group0 source pulses
  output logic      [63:0] cpu_req,         // per-source requests
  output logic             cpu_req_any,     // any forwarded request
  output logic             irq              // summary interrupt
);

  // ****************************************
  // bus decode
  // ****************************************
  logic        wr_acc;
  logic        rd_acc;
  logic        lo_ok;
  logic [15:0] wlo;
  logic [NGRP-1:0] wr_flags;
  logic [NGRP-1:0] wr_en;
  logic        hit;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign lo_ok  = &pstrb[1:0];
  assign wlo    = pwdata[15:0];
  assign pready = 1'b1;

  // ****************************************
  // groups: 0=flags2 1=flags3 2=flags4 3=en0
  // ****************************************
  localparam logic [15:0] GMASK [4] = '{ifeb_pkg::MASK_FLAGS2, ifeb_pkg::MASK_FLAGS3,
                                         ifeb_pkg::MASK_FLAGS4, ifeb_pkg::MASK_EN0};
  localparam logic [11:0] FOFS [4] = '{ifeb_pkg::OFS_FLAGS2, ifeb_pkg::OFS_FLAGS3,
                                        ifeb_pkg::OFS_FLAGS4, 12'hFFC};
  localparam logic [11:0] EOFS [4] = '{ifeb_pkg::OFS_EN2, ifeb_pkg::OFS_EN3,
                                        ifeb_pkg::OFS_EN4, ifeb_pkg::OFS_EN0};
  // group0 flags have no bus address, so no write may reach them
  localparam logic        FMAP [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  logic [15:0] srcs [4];
  ifeb_pkg::ifeb_grp_t gq [4];
  logic [15:0] greq [4];
  logic [NGRP-1:0] gnew;

  assign srcs[0] = src_group2;
  assign srcs[1] = src_group3;
  assign srcs[2] = src_group4;
  assign srcs[3] = src_group0;

  genvar g;
  generate
    for (g = 0; g < NGRP; g++) begin : g_grp
      assign wr_flags[g] = wr_acc & lo_ok & FMAP[g] & (paddr == FOFS[g]);
      assign wr_en[g]    = wr_acc & lo_ok & (paddr == EOFS[g]);
      ifeb_group #(
        .MASK(GMASK[g])
      ) u_grp (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .src_req  (srcs[g]),
        .wr_flags (wr_flags[g]),
        .wr_en    (wr_en[g]),
        .wdata    (wlo),
        .q        (gq[g]),
        .req_out  (greq[g]),
        .new_req  (gnew[g])
      );
      assign cpu_req[16*g +: 16] = greq[g];
    end
  endgenerate

  // enable group0 has no flags register of its own in this map
  // fixed positions via masks and source ports
  assign cpu_req_any = |cpu_req;

  // ****************************************
  // interrupt summary state
  // ****************************************
  typedef struct packed {
    logic [ifeb_pkg::EVT_W-1:0] stat;
    logic [ifeb_pkg::EVT_W-1:0] ien;
    logic                       any_q;
    ifeb_pkg::ifeb_rsp_t        rsp;
  } ifeb_top_t;

  ifeb_top_t st;
  ifeb_top_t next_st;
  logic [ifeb_pkg::EVT_W-1:0] evt;
  logic [31:0] rd_mux;

  always_comb begin
    evt = '0;
    evt[ifeb_pkg::EVT_NEW_REQ] = |gnew;
    evt[ifeb_pkg::EVT_SW_SET]  = |(wr_flags & {NGRP{|wlo}});
    evt[ifeb_pkg::EVT_IRQ_UP]  = cpu_req_any & ~st.any_q;
  end

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      ifeb_pkg::OFS_FLAGS2:   rd_mux = {16'h0000, gq[0].flags};
      ifeb_pkg::OFS_FLAGS3:   rd_mux = {16'h0000, gq[1].flags};
      ifeb_pkg::OFS_FLAGS4:   rd_mux = {16'h0000, gq[2].flags};
      ifeb_pkg::OFS_EN0:      rd_mux = {16'h0000, gq[3].en};
      ifeb_pkg::OFS_EN2:      rd_mux = {16'h0000, gq[0].en};
      ifeb_pkg::OFS_EN3:      rd_mux = {16'h0000, gq[1].en};
      ifeb_pkg::OFS_EN4:      rd_mux = {16'h0000, gq[2].en};
      ifeb_pkg::OFS_IRQ_STAT: rd_mux = {29'h0000_0000, st.stat};
      ifeb_pkg::OFS_IRQ_CLR:  rd_mux = 32'h0000_0000;
      ifeb_pkg::OFS_IRQ_EN:   rd_mux = {29'h0000_0000, st.ien};
      default:                hit = 1'b0;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.any_q = cpu_req_any;
    if (wr_acc && paddr == ifeb_pkg::OFS_IRQ_CLR) begin
      next_st.stat = st.stat & ~pwdata[ifeb_pkg::EVT_W-1:0];
    end
    if (wr_acc && paddr == ifeb_pkg::OFS_IRQ_EN) begin
      next_st.ien = pwdata[ifeb_pkg::EVT_W-1:0];
    end
    // events win over a same-cycle clear
    next_st.stat = next_st.stat | evt;
    next_st.rsp.pslverr = psel & ~penable & ~hit;
    next_st.rsp.prdata  = (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata  = st.rsp.prdata;
  assign pslverr = st.rsp.pslverr & psel & penable;
  assign irq     = |(st.stat & st.ien);

endmodule // ifeb_bank

//--- ifeb_bank_props.sv
`timescale 1ns/100ps
module ifeb_bank_props (
  input wire logic        clk,        // clock
  input wire logic        sys_rst,    // reset
  input wire logic        psel,       // select
  input wire logic        penable,    // enable
  input wire logic        pwrite,     // write
  input wire logic [11:0] paddr,      // address
  input wire logic [31:0] prdata,     // read data
  input wire logic        pslverr,    // error
  input wire logic [15:0] src_group2, // sources
  input wire logic [15:0] src_group4, // sources
  input wire logic [63:0] cpu_req,    // requests
  input wire logic        cpu_req_any // any request
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire wr = psel && penable && pwrite;
  a_any_or: assert property (cpu_req_any == |cpu_req) else $error("any mismatch");
  a_grp2_cause: assert property (!$past(wr) |->
    (cpu_req[15:0] & ~$past(cpu_req[15:0]) & ~$past(src_group2)) == 16'h0000) else $error("group2 uncaused");
  a_grp4_cause: assert property (!$past(wr) |->
    (cpu_req[47:32] & ~$past(cpu_req[47:32]) & ~$past(src_group4)) == 16'h0000) else $error("group4 uncaused");
  a_req_sticky: assert property (!wr |=> (cpu_req & $past(cpu_req)) == $past(cpu_req)) else $error("lost");
  a_unimpl_low: assert property ((cpu_req[31:0] & ~{ifeb_pkg::MASK_FLAGS3, ifeb_pkg::MASK_FLAGS2}) == 32'h0)
    else $error("unassigned low");
  a_unimpl_high: assert property ((cpu_req[63:32] & ~{ifeb_pkg::MASK_EN0, ifeb_pkg::MASK_FLAGS4}) == 32'h0)
    else $error("unassigned high");
  a_rd_upper: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0) else $error("upper");
  a_unmapped: assert property (psel && penable && paddr > 12'h024 |-> pslverr) else $error("unmapped");
  c_err: cover property (psel && penable && pslverr);
  c_any: cover property ($rose(cpu_req_any));
  c_src: cover property (|src_group2);
endmodule // ifeb_bank_props

bind ifeb_bank ifeb_bank_props u_props (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .src_group2(src_group2),
  .src_group4(src_group4), .cpu_req(cpu_req), .cpu_req_any(cpu_req_any));

//--- ifeb_bank_tb_top.sv
`timescale 1ns/100ps
module ifeb_bank_tb_top;
  logic        clk = 1'b0;
  logic        sys_rst, psel, penable, pwrite, pready, pslverr, cpu_req_any, irq, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  pstrb;
  logic [15:0] src_group2, src_group3, src_group4, src_group0, acc, rnd;
  logic [63:0] cpu_req;
  int          n_fail = 0;
  int          checked = 0;
  logic [11:0] eofs [4] = '{ifeb_pkg::OFS_EN2, ifeb_pkg::OFS_EN3, ifeb_pkg::OFS_EN4, ifeb_pkg::OFS_EN0};
  logic [15:0] msk [4] = '{ifeb_pkg::MASK_FLAGS2, ifeb_pkg::MASK_FLAGS3, ifeb_pkg::MASK_FLAGS4, ifeb_pkg::MASK_EN0};
  always #25 clk = ~clk;
  ifeb_bank dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_group2(src_group2),
    .src_group3(src_group3), .src_group4(src_group4), .src_group0(src_group0), .cpu_req(cpu_req),
    .cpu_req_any(cpu_req_any), .irq(irq));
  task automatic give_verdict;
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      give_verdict();
    end
    rv = prdata;
    ev = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic pulse(input logic [63:0] v);
    @(posedge clk);
    {src_group0, src_group4, src_group3, src_group2} <= v;
    @(posedge clk);
    {src_group0, src_group4, src_group3, src_group2} <= 64'h0;
  endtask
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {src_group0, src_group4, src_group3, src_group2} = 64'h0;
    pstrb = 4'hC;
    void'($urandom(14920));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 40; a += 4) begin
      apb(1'b0, 12'(a), 32'h0);
      chk("reset", 64'h0, 64'(rv));
    end
    apb(1'b1, ifeb_pkg::OFS_EN2, 32'hFFFFFFFF);
    pstrb <= 4'hF;
    apb(1'b0, ifeb_pkg::OFS_EN2, 32'h0);
    chk("strobe", 64'h0, 64'(rv));
    chk("no error", 64'h0, 64'(ev));
    apb(1'b0, 12'h028, 32'h0);
    chk("unmapped", 64'h1, 64'(ev));
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, eofs[g], 32'hFFFFFFFF);
      apb(1'b0, eofs[g], 32'h0);
      chk("enable", 64'(msk[g]), 64'(rv));
    end
    for (int b = 0; b < 3; b++) begin
      pulse(64'h1 << b);
      apb(1'b0, ifeb_pkg::OFS_FLAGS2, 32'h0);
      chk("group2", 64'h1 << b, 64'(rv));
      chk("request", 64'h1 << b, cpu_req);
      apb(1'b1, ifeb_pkg::OFS_FLAGS2, 32'h0);
    end
    pulse(64'h80 << 32);
    apb(1'b0, ifeb_pkg::OFS_FLAGS4, 32'h0);
    chk("group4", 64'h80, 64'(rv));
    apb(1'b1, ifeb_pkg::OFS_FLAGS4, 32'hFFFFFFFF);
    apb(1'b0, ifeb_pkg::OFS_FLAGS4, 32'h0);
    chk("flags4", 64'(ifeb_pkg::MASK_FLAGS4), 64'(rv));
    apb(1'b1, ifeb_pkg::OFS_FLAGS4, 32'h0);
    pulse(64'h1 << 59);
    @(negedge clk);
    chk("async1", 64'h1 << 59, cpu_req);
    chk("any", 64'h1, 64'(cpu_req_any));
    apb(1'b1, ifeb_pkg::OFS_EN0, 32'h0);
    apb(1'b0, ifeb_pkg::OFS_EN0, 32'h0);
    chk("blocked", 64'h0, cpu_req);
    chk("any off", 64'h0, 64'(cpu_req_any));
    apb(1'b1, ifeb_pkg::OFS_EN3, 32'h0);
    acc = 16'h0000;
    repeat (5) begin
      rnd = 16'($urandom);
      acc = acc | rnd;
      pulse(64'(rnd) << 16);
      apb(1'b0, ifeb_pkg::OFS_FLAGS3, 32'h0);
      chk("sticky", 64'(acc & msk[1]), 64'(rv));
      chk("masked", 64'h0, cpu_req);
    end
    apb(1'b1, ifeb_pkg::OFS_EN3, 32'hFFFFFFFF);
    apb(1'b1, ifeb_pkg::OFS_IRQ_CLR, 32'h7);
    chk("forward", 64'(acc & msk[1]) << 16, cpu_req);
    apb(1'b1, ifeb_pkg::OFS_IRQ_EN, 32'h1);
    apb(1'b0, ifeb_pkg::OFS_IRQ_STAT, 32'h0);
    chk("irq idle", 64'h0, 64'(irq));
    pulse(64'h1);
    apb(1'b0, ifeb_pkg::OFS_IRQ_STAT, 32'h0);
    chk("status", 64'h1, 64'(rv[0]));
    chk("irq up", 64'h1, 64'(irq));
    apb(1'b1, ifeb_pkg::OFS_IRQ_EN, 32'h0);
    apb(1'b1, ifeb_pkg::OFS_IRQ_CLR, 32'h7);
    chk("irq masked", 64'h0, 64'(irq));
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, ifeb_pkg::OFS_FLAGS3, 32'h0);
    chk("rst flags", 64'h0, 64'(rv));
    chk("rst req", 64'h0, cpu_req);
    apb(1'b0, ifeb_pkg::OFS_EN3, 32'h0);
    chk("rst enable", 64'h0, 64'(rv));
    give_verdict();
  end
endmodule // ifeb_bank_tb_top

//--- ifeb_group.sv
`timescale 1ns/100ps
// one flag/enable register pair with sticky flags
module ifeb_group #(
  parameter logic [15:0] MASK = 16'hFFFF
) (
  input  wire logic        clk,        // system clock
  input  wire logic        sys_rst,    // async reset, high
  input  wire logic [15:0] src_req,    // source request pulses
  input  wire logic        wr_flags,   // write strobe for flags
  input  wire logic        wr_en,      // write strobe for enables
  input  wire logic [15:0] wdata,      // write data
  output ifeb_pkg::ifeb_grp_t q,       // current flags and enables
  output logic [15:0]      req_out,    // forwarded requests
  output logic             new_req     // a source pulse sets a clear flag this cycle
);

  ifeb_pkg::ifeb_grp_t state;
  ifeb_pkg::ifeb_grp_t next_state;

  always_comb begin
    next_state = state;
    if (wr_flags) begin
      next_state.flags = wdata & MASK;
    end
    if (wr_en) begin
      next_state.en = wdata & MASK;
    end
    next_state.flags = next_state.flags | (src_req & MASK);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '{flags: ifeb_pkg::RESET_VAL, en: ifeb_pkg::RESET_VAL};
    end else begin
      state <= next_state;
    end
  end

  assign q = state;
  assign req_out = state.flags & state.en;
  assign new_req = |(src_req & MASK & ~state.flags);

endmodule // ifeb_group

//--- ifeb_pkg.sv
package ifeb_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] OFS_FLAGS2   = 12'h000;
  localparam logic [11:0] OFS_FLAGS3   = 12'h004;
  localparam logic [11:0] OFS_FLAGS4   = 12'h008;
  localparam logic [11:0] OFS_EN0      = 12'h00C;
  localparam logic [11:0] OFS_EN2      = 12'h010;
  localparam logic [11:0] OFS_EN3      = 12'h014;
  localparam logic [11:0] OFS_EN4      = 12'h018;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h01C;
  localparam logic [11:0] OFS_IRQ_CLR  = 12'h020;
  localparam logic [11:0] OFS_IRQ_EN   = 12'h024;

  // ****************************************
  // implemented bit masks
  // ****************************************
  localparam int          REG_W      = 16;
  localparam logic [15:0] MASK_FLAGS2 = 16'hDFFF;
  localparam logic [15:0] MASK_FLAGS3 = 16'h21FF;
  localparam logic [15:0] MASK_FLAGS4 = 16'h00F6;
  localparam logic [15:0] MASK_EN0    = 16'h7FFF;
  localparam logic [15:0] RESET_VAL   = 16'h0000;

  // ****************************************
  // named bit positions
  // ****************************************
  localparam int BIT_CAN1_RX_READY  = 2;
  localparam int BIT_SERIAL2_EVENT  = 1;
  localparam int BIT_SERIAL2_ERROR  = 0;
  localparam int BIT_CAN2_TX_REQ    = 7;
  localparam int BIT_ASYNC1_RX_EN   = 11;

  // ****************************************
  // interrupt event bits
  // ****************************************
  localparam int EVT_W       = 3;
  localparam int EVT_NEW_REQ = 0;
  localparam int EVT_SW_SET  = 1;
  localparam int EVT_IRQ_UP  = 2;

  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] en;
  } ifeb_grp_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pslverr;
  } ifeb_rsp_t;

endpackage
